// ==== rwp_regs.svh ====
`ifndef RWP_REGS_SVH
`define RWP_REGS_SVH
// What this block does
// - Writes to the clock, oscillation-stop and on-chip oscillator registers pass only while bit 0 is set.
// - Writes to the two processor mode registers pass only while bit 1 is set.
// - Writes to the port 0 direction register pass only while bit 2 is set.
// - Writes to the six voltage detection and reference registers pass only while bit 3 is set.
// - Bit 2 clears itself on the next write to any other register in the area after it was set.
// - Bits 0, 1 and 3 stay set across protected writes until software clears them.
// - Bit 7 reads as zero; bits 4 to 6 are reserved and written with zero.
// - Guarded registers cannot be overwritten unless their group enable is set.

`define RWP_ADDR_W        16
`define RWP_CTRL_OFF      16'h000a
`define RWP_CTRL_RESET    8'h00
`define RWP_BIT_CLK       0
`define RWP_BIT_PWR       1
`define RWP_BIT_PORT      2
`define RWP_BIT_VOLT      3
`define RWP_RW_MASK       8'h7f
`define RWP_CLK_CTL0_OFF  16'h0006
`define RWP_CLK_CTL1_OFF  16'h0007
`define RWP_CLK_CTL3_OFF  16'h0008
`define RWP_OSC_STOP_OFF  16'h000c
`define RWP_OSC0_OFF      16'h0023
`define RWP_OSC1_OFF      16'h0024
`define RWP_OSC2_OFF      16'h0025
`define RWP_OSC3_OFF      16'h0029
`define RWP_PMODE0_OFF    16'h0004
`define RWP_PMODE1_OFF    16'h0005
`define RWP_PORT0_DIR_OFF 16'h00e2
`define RWP_VREF_OFF      16'h0026
`define RWP_VDET2_OFF     16'h0032
`define RWP_VLSEL1_OFF    16'h0036
`define RWP_VMON0_OFF     16'h0038
`define RWP_VMON1_OFF     16'h0039
`define RWP_VMON2_OFF     16'h003a
`define RWP_SFR_LAST      16'h02ff
`endif

// ==== rwp_pkg.sv ====
package rwp_pkg;
	typedef enum logic [2:0] {
		RWP_GRP_NONE,
		RWP_GRP_CLK,
		RWP_GRP_PWR,
		RWP_GRP_PORT,
		RWP_GRP_VOLT
	} rwp_group_t;
endpackage

// ==== rwp_write_protect.sv ====
`timescale 1ns/10ps
`include "rwp_regs.svh"
module rwp_write_protect (
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	input  wire logic [`RWP_ADDR_W-1:0] addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic [7:0]                  rdata,
	output logic                        sfr_wr_allow,
	output logic [3:0]                  group_enable
);
	logic [7:0]          write_protect_control;
	rwp_pkg::rwp_group_t grp;
	logic                in_sfr;
	logic                ctrl_hit;
	logic                blocked_wr;

	// decode shared by the gate and the checks
	function automatic rwp_pkg::rwp_group_t group_of(
		input logic [`RWP_ADDR_W-1:0] a);
		case (a)
		`RWP_CLK_CTL0_OFF,
		`RWP_CLK_CTL1_OFF,
		`RWP_CLK_CTL3_OFF,
		`RWP_OSC_STOP_OFF,
		`RWP_OSC0_OFF,
		`RWP_OSC1_OFF,
		`RWP_OSC2_OFF,
		`RWP_OSC3_OFF:
			group_of = rwp_pkg::RWP_GRP_CLK;
		`RWP_PMODE0_OFF,
		`RWP_PMODE1_OFF:
			group_of = rwp_pkg::RWP_GRP_PWR;
		`RWP_PORT0_DIR_OFF:
			group_of = rwp_pkg::RWP_GRP_PORT;
		`RWP_VREF_OFF,
		`RWP_VDET2_OFF,
		`RWP_VLSEL1_OFF,
		`RWP_VMON0_OFF,
		`RWP_VMON1_OFF,
		`RWP_VMON2_OFF:
			group_of = rwp_pkg::RWP_GRP_VOLT;
		default:
			group_of = rwp_pkg::RWP_GRP_NONE;
		endcase
	endfunction

	assign grp      = group_of(addr);
	assign in_sfr   = (addr <= `RWP_SFR_LAST);
	assign ctrl_hit = (addr == `RWP_CTRL_OFF);

	// only used by the checks below
	assign blocked_wr = wr && (grp != rwp_pkg::RWP_GRP_NONE)
		&& !sfr_wr_allow;

	// bits 4..6 stored as written, bit 7 never stored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			write_protect_control <= `RWP_CTRL_RESET;
		end else if (wr && ctrl_hit) begin
			write_protect_control <= wdata & `RWP_RW_MASK;
		end else if (wr && in_sfr) begin
			// other enables untouched by protected writes
			write_protect_control[`RWP_BIT_PORT] <= 1'b0;
		end
	end

	// combinational gate: the target register samples it with its strobe
	always_comb begin
		case (grp)
		rwp_pkg::RWP_GRP_CLK:
			sfr_wr_allow = wr && write_protect_control[`RWP_BIT_CLK];
		rwp_pkg::RWP_GRP_PWR:
			sfr_wr_allow = wr && write_protect_control[`RWP_BIT_PWR];
		rwp_pkg::RWP_GRP_PORT:
			sfr_wr_allow = wr && write_protect_control[`RWP_BIT_PORT];
		rwp_pkg::RWP_GRP_VOLT:
			sfr_wr_allow = wr && write_protect_control[`RWP_BIT_VOLT];
		default:
			sfr_wr_allow = wr && !ctrl_hit; // unguarded registers
		endcase
	end
	// a blocked write simply never reaches the target

	assign group_enable = write_protect_control[3:0];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (rd && ctrl_hit) begin
			rdata <= write_protect_control & `RWP_RW_MASK;
		end else begin
			rdata <= 8'h00;
		end
	end

	sequence s_port_set;
		wr && ctrl_hit && wdata[2];
	endsequence

	sequence s_other_sfr_wr;
		wr && in_sfr && !ctrl_hit;
	endsequence

	sequence s_ctrl_wr;
		wr && ctrl_hit;
	endsequence

	sequence s_ctrl_rd;
		rd && ctrl_hit;
	endsequence

	sequence s_outside_wr;
		wr && !in_sfr;
	endsequence

	// no disable here: this one watches the reset itself
	chk_reset_clear: assert property (@(posedge clk_sys)
		srst |=> write_protect_control == 8'h00 && rdata == 8'h00)
		else $error("reset value wrong");

	chk_clk_blocked: assert property (@(posedge clk_sys) disable iff (srst)
		(grp == rwp_pkg::RWP_GRP_CLK && !write_protect_control[0])
		|-> !sfr_wr_allow) else $error("clock group write passed");

	chk_clk_gate: assert property (@(posedge clk_sys) disable iff (srst)
		(grp == rwp_pkg::RWP_GRP_CLK && wr)
		|-> sfr_wr_allow == write_protect_control[0])
		else $error("clock group gate wrong");

	chk_pwr_gate: assert property (@(posedge clk_sys) disable iff (srst)
		(grp == rwp_pkg::RWP_GRP_PWR && wr)
		|-> sfr_wr_allow == write_protect_control[1])
		else $error("power group gate wrong");
	chk_port_gate: assert property (@(posedge clk_sys) disable iff (srst)
		(grp == rwp_pkg::RWP_GRP_PORT && wr)
		|-> sfr_wr_allow == write_protect_control[2])
		else $error("port group gate wrong");
	chk_volt_gate: assert property (@(posedge clk_sys) disable iff (srst)
		(grp == rwp_pkg::RWP_GRP_VOLT && wr)
		|-> sfr_wr_allow == write_protect_control[3])
		else $error("voltage group gate wrong");

	chk_port_autoclear: assert property (@(posedge clk_sys) disable iff (srst)
		s_port_set ##1 s_other_sfr_wr |=> !write_protect_control[2])
		else $error("port enable not cleared");

	chk_port_spent: assert property (@(posedge clk_sys) disable iff (srst)
		s_other_sfr_wr |=> !write_protect_control[2])
		else $error("port enable survived a write");

	// writes past the area end must not spend the one-shot
	chk_outside_keep: assert property (@(posedge clk_sys) disable iff (srst)
		s_outside_wr |=> write_protect_control
			== $past(write_protect_control))
		else $error("outside write changed control");

	chk_idle_hold: assert property (@(posedge clk_sys) disable iff (srst)
		!wr |=> write_protect_control == $past(write_protect_control))
		else $error("control changed without write");

	chk_sticky_en: assert property (@(posedge clk_sys) disable iff (srst)
		(wr && !ctrl_hit) |=> write_protect_control[1:0]
			== $past(write_protect_control[1:0])
			&& write_protect_control[3] == $past(write_protect_control[3]))
		else $error("sticky enable changed");

	chk_ctrl_load: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_wr |=> write_protect_control
			== ($past(wdata) & 8'h7f))
		else $error("control load wrong");

	chk_ctrl_no_pass: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_wr |-> !sfr_wr_allow)
		else $error("control write leaked out");

	chk_free_pass: assert property (@(posedge clk_sys) disable iff (srst)
		(wr && grp == rwp_pkg::RWP_GRP_NONE && !ctrl_hit)
		|-> sfr_wr_allow)
		else $error("unguarded write refused");

	chk_no_strobe: assert property (@(posedge clk_sys) disable iff (srst)
		!wr |-> !sfr_wr_allow)
		else $error("allow without strobe");

	chk_bit7_store: assert property (@(posedge clk_sys) disable iff (srst)
		write_protect_control[7] == 1'b0)
		else $error("bit 7 stored");

	chk_bit7_zero: assert property (@(posedge clk_sys) disable iff (srst)
		s_ctrl_rd |=> rdata[7] == 1'b0
			&& rdata[6:0] == $past(write_protect_control[6:0]))
		else $error("read value wrong");

	chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (srst)
		!(rd && ctrl_hit) |=> rdata == 8'h00)
		else $error("read data not cleared");

	chk_group_mirror: assert property (@(posedge clk_sys) disable iff (srst)
		group_enable == write_protect_control[3:0])
		else $error("enable outputs wrong");

	// a refused write may only spend the port one-shot
	chk_blocked_quiet: assert property (@(posedge clk_sys) disable iff (srst)
		blocked_wr
		|=> write_protect_control[7:3] == $past(write_protect_control[7:3])
			&& write_protect_control[1:0]
			== $past(write_protect_control[1:0]))
		else $error("blocked write side effect");
endmodule

// ==== register_write_protect_tb.sv ====
`timescale 1ns/10ps
`include "rwp_regs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module register_write_protect_tb;
	logic        clk_sys = 1'b0;
	logic        srst    = 1'b1;
	logic [15:0] addr    = 16'h0000;
	logic [7:0]  wdata   = 8'h00;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [7:0]  rdata;
	logic        sfr_wr_allow;
	logic [3:0]  group_enable;
	int          n_fail  = 0;
	int          tests_run = 0;
	// guarded offsets and the enable bit of each
	logic [15:0] ga [18] = '{16'h0006, 16'h0007, 16'h0008, 16'h000c,
		16'h0023, 16'h0024, 16'h0025, 16'h0029, 16'h0004, 16'h0005,
		16'h00e2, 16'h0026, 16'h0032, 16'h0036, 16'h0038, 16'h0039,
		16'h003a, 16'h003a};
	int          gb [18] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 2, 3, 3, 3, 3, 3,
		3, 3};
	rwp_write_protect uut (
		.clk_sys      (clk_sys),
		.srst         (srst),
		.addr         (addr),
		.wdata        (wdata),
		.wr           (wr),
		.rd           (rd),
		.rdata        (rdata),
		.sfr_wr_allow (sfr_wr_allow),
		.group_enable (group_enable)
	);
	always #10 clk_sys = ~clk_sys;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one write cycle; allow is looked at while the strobe is up
	task automatic wr_op(input logic [15:0] a, input logic [7:0] d,
		input logic ea, input logic [3:0] eg);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		#1 `CHK(sfr_wr_allow, ea)
		@(posedge clk_sys);
		wr <= 1'b0;
		#1 `CHK(group_enable, eg)
	endtask
	task automatic rd_op(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		rd_op(`RWP_CTRL_OFF, `RWP_CTRL_RESET);
		rd_op(`RWP_CLK_CTL0_OFF, 8'h00);
		// all groups closed: every guarded write refused
		for (int i = 0; i < 18; i++) wr_op(ga[i], 8'h5a, 1'b0, 4'h0);
		wr_op(`RWP_CTRL_OFF, 8'h0b, 1'b0, 4'hb);
		// sticky enables open their groups and survive the writes
		for (int i = 0; i < 18; i++) wr_op(ga[i], 8'ha5, gb[i] != 2, 4'hb);
		wr_op(`RWP_CTRL_OFF, 8'h04, 1'b0, 4'h4);
		// no other area access between the set and the port write
		wr_op(`RWP_PORT0_DIR_OFF, 8'h3c, 1'b1, 4'h0);
		wr_op(`RWP_PORT0_DIR_OFF, 8'h3c, 1'b0, 4'h0);
		// any area write, even a refused one, spends the one-shot
		wr_op(`RWP_CTRL_OFF, 8'h04, 1'b0, 4'h4);
		wr_op(`RWP_PMODE0_OFF, 8'h01, 1'b0, 4'h0);
		// a write beyond the area leaves the one-shot armed
		wr_op(`RWP_CTRL_OFF, 8'h04, 1'b0, 4'h4);
		wr_op(16'h0300, 8'h01, 1'b1, 4'h4);
		wr_op(`RWP_PORT0_DIR_OFF, 8'h0f, 1'b1, 4'h0);
		wr_op(`RWP_CTRL_OFF, 8'hff, 1'b0, 4'hf);
		rd_op(`RWP_CTRL_OFF, `RWP_RW_MASK);
		wr_op(`RWP_VMON2_OFF, 8'h11, 1'b1, 4'hb);
		wr_op(`RWP_CTRL_OFF, 8'h00, 1'b0, 4'h0);
		wr_op(`RWP_CLK_CTL1_OFF, 8'h01, 1'b0, 4'h0);
		end_sim();
	end
endmodule
